// file: dv/event_buffer.sv
`timescale 1ns/1ps
module event_buffer
    import power_stage_pkg::*;
(
    // Clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // Event stream
    input  wire logic            evt_valid,
    input  wire logic [4:0]      evt_code,
    // Count per event slot
    output logic [NEVT-1:0][7:0] ev_cnt
);
    int idx;
    assign idx = int'(evt_code[4:3]) * NKIND + int'(evt_code[2:0]);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_cnt <= '0;
        end else if (evt_valid && evt_code[2:0] <= 3'h5) begin
            ev_cnt[idx] <= ev_cnt[idx] + 8'h01;
        end
    end
endmodule // event_buffer

// file: dv/power_stage_assertions.sv
`timescale 1ns/1ps
module power_stage_assertions
    import power_stage_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int MS_CYCLES   = MS_CYCLES_DEF
) (
    // Clock and reset
    input wire logic           hclk,
    input wire logic           hresetn,
    // Stage outputs
    input wire logic [NST-1:0] start_out,
    input wire logic [NST-1:0] trip_out,
    input wire logic [NST-1:0] blocked_out,
    // Event stream
    input wire logic           evt_valid,
    input wire logic [4:0]     evt_code,
    input wire logic [31:0]    evt_stamp
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_hold; $changed(start_out) |=> $stable(start_out)[*8]; endproperty
    a_hold: assert property (p_hold) else $error("start moved off tick");
    property p_excl; (blocked_out & (start_out | trip_out)) == '0; endproperty
    a_excl: assert property (p_excl) else $error("blocked with start");
    property p_trip; (trip_out & ~start_out) == '0; endproperty
    a_trip: assert property (p_trip) else $error("trip without start");
    property p_son;
        $rose(start_out[0]) |-> ##[1:24] (evt_valid && evt_code == 5'h00);
    endproperty
    a_son: assert property (p_son) else $error("no start event");
    property p_kind; evt_valid |-> evt_code[2:0] <= 3'h5; endproperty
    a_kind: assert property (p_kind) else $error("bad event kind");
    property p_stamp;
        evt_valid && $past(evt_valid) |-> evt_stamp == $past(evt_stamp);
    endproperty
    a_stamp: assert property (p_stamp) else $error("stamp split");
    property p_soff;
        $rose(blocked_out[0]) && $past(start_out[0])
            |-> ##[1:24] (evt_valid && evt_code == 5'h01);
    endproperty
    a_soff: assert property (p_soff) else $error("no start off");
    property p_bon;
        $rose(blocked_out[0]) |-> ##[1:24] (evt_valid && evt_code == 5'h04);
    endproperty
    a_bon: assert property (p_bon) else $error("no block event");
endmodule // power_stage_assertions

bind power_stage power_stage_assertions #(
    .TICK_CYCLES(TICK_CYCLES),
    .MS_CYCLES  (MS_CYCLES)
) u_chk (.hclk, .hresetn, .start_out, .trip_out, .blocked_out,
         .evt_valid, .evt_code, .evt_stamp);

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
    import power_stage_pkg::*;
    localparam int TK = 64;
    logic                   hclk = 1'b0;
    logic                   hresetn = 1'b0;
    logic                   hsel, hwrite, hreadyout, hresp, evt_valid;
    logic [31:0]            haddr, hwdata, hrdata, rdv, stv;
    logic [1:0]             htrans;
    logic [NST-1:0][PW-1:0] meas_power;
    logic [2:0]             setting_group;
    logic [NST-1:0]         block_in, start_out, trip_out, blocked_out;
    logic [4:0]             evt_code;
    logic [31:0]            evt_stamp, last_stamp;
    logic [PW-1:0]          evt_power, last_power;
    logic [NEVT-1:0][7:0]   ev_cnt;
    int                     n_fail = 0;
    int                     n_tests = 0;
    int                     c;

    always #5 hclk = ~hclk;

    power_stage #(.TICK_CYCLES(TK), .MS_CYCLES(10)) u_dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .meas_power, .setting_group, .block_in, .start_out, .trip_out,
        .blocked_out, .evt_valid, .evt_code, .evt_stamp, .evt_power);
    event_buffer u_evb (.hclk, .hresetn, .evt_valid, .evt_code, .ev_cnt);
    always @(posedge hclk) begin
        if (evt_valid === 1'b1) begin
            last_stamp <= evt_stamp;
            last_power <= evt_power;
        end
    end

    task conclude;
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task hwait;
        c = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            c++;
            if (c > 50) begin
                n_fail++;
                conclude;
            end
            @(posedge hclk);
        end
    endtask
    // Address phase held until ready, then data phase held until ready
    task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hwait;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        hwait;
        rdv = hrdata;
    endtask
    task rc(input logic [31:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rdv, e);
    endtask
    task ticks(input int n);
        repeat (n * TK) @(posedge hclk);
        #1;
    endtask

    initial begin
        {hsel, hwrite, haddr, hwdata, htrans, setting_group} = '0;
        block_in = '0;
        // Negative power keeps a zero pick-up from operating
        meas_power = {NST{32'hFFFF_FFFF}};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rc(OFF_CTRL, 32'h0000_0100);
        rc(OFF_EVT_EN, 32'h00FF_FFFF);
        rc(OFF_NOMINAL, 32'h0000_2710);
        rc(32'h0000_0040, 32'h0000_0008);
        rc(OFF_LOG_INFO, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            xfer(OFF_CTRL, 1'b1, 32'h0000_0100 | (i << 12));
            rc(OFF_STATUS, 32'h0000_1000 | ((i > 4 ? 4 : i) << 8));
        end
        for (int n = 5; n > 0; n--) begin
            xfer(OFF_CTRL, 1'b1, n << 8);
            rc(OFF_STATUS, n << 12);
        end
        xfer(32'h0000_0100, 1'b1, 32'h0000_03E8);
        xfer(32'h0000_0104, 1'b1, 32'h0000_07D0);
        setting_group <= 3'h1;
        ticks(2);
        rc(32'h0000_0080, 32'h0000_07D0);
        setting_group <= 3'h0;
        ticks(2);
        rc(32'h0000_0080, 32'h0000_03E8);
        xfer(32'h0000_0040, 1'b1, 32'h0000_0003);
        meas_power[0] <= 32'h0000_05DC;
        for (c = 0; c < 300 && start_out[0] !== 1'b1; c++) @(posedge hclk);
        if (c >= 300) begin
            n_fail++;
            conclude;
        end
        for (c = 0; c < 900 && trip_out[0] !== 1'b1; c++) @(posedge hclk);
        chk(c, 3 * TK);
        if (c >= 900) begin
            conclude;
        end
        rc(32'h0000_0044, 32'h0000_0096);
        rc(32'h0000_0048, 32'h0000_000F);
        rc(OFF_STATUS, 32'h0000_1002);
        rc(OFF_LOG_INFO, 32'h0000_0022);
        chk(last_power, 32'h0000_05DC);
        xfer(OFF_LOG_SEL, 1'b1, 32'h0000_0001);
        rc(32'h0000_0018, 32'h0000_0002);
        rc(32'h0000_0020, 32'h0000_05DC);
        rc(32'h0000_0014, last_stamp);
        chk({ev_cnt[0], ev_cnt[2]}, 32'h0000_0101);
        meas_power[0] <= 32'h0000_03D4;
        ticks(2);
        chk(trip_out[0], 1);
        meas_power[0] <= 32'h0000_03C0;
        ticks(2);
        chk({start_out[0], trip_out[0]}, 0);
        xfer(32'h0000_0040, 1'b1, 32'h0000_0014);
        block_in[0] <= 1'b1;
        ticks(1);
        meas_power[0] <= 32'h0000_05DC;
        ticks(3);
        chk({blocked_out[0], start_out[0]}, 2);
        rc(OFF_STATUS, 32'h0000_1003);
        block_in[0] <= 1'b0;
        ticks(3);
        chk(start_out[0], 1);
        block_in[0] <= 1'b1;
        ticks(2);
        chk({blocked_out[0], start_out[0], trip_out[0]}, 4);
        chk(ev_cnt[1], 2);
        xfer(OFF_CTRL, 1'b1, 32'h0000_0112);
        block_in[0] <= 1'b0;
        ticks(3);
        chk(blocked_out[0], 1);
        xfer(OFF_CTRL, 1'b1, 32'h0000_0100);
        ticks(3);
        chk(start_out[0], 1);
        xfer(OFF_EVT_EN, 1'b1, 32'h0000_0001);
        meas_power[0] <= 32'hFFFF_FFFF;
        ticks(3);
        chk({start_out[0], ev_cnt[1]}, 2);
        xfer(32'h0000_0040, 1'b1, 32'h0000_0000);
        meas_power[0] <= 32'h0000_05DC;
        ticks(2);
        chk({start_out[0], trip_out[0]}, 3);
        xfer(OFF_LOG_SEL, 1'b1, 32'h0000_0006);
        xfer(32'h0000_0014, 1'b0, 32'h0000_0000);
        stv = rdv;
        xfer(OFF_LOG_SEL, 1'b1, 32'h0000_0007);
        rc(32'h0000_0014, stv);
        xfer(OFF_CTRL, 1'b1, 32'h0000_0101);
        meas_power[0] <= 32'h0000_0410;
        ticks(2);
        chk(start_out[0], 0);
        meas_power[0] <= 32'h0000_03E8;
        ticks(2);
        chk(trip_out[0], 1);
        meas_power[0] <= 32'h0000_0404;
        ticks(2);
        chk(trip_out[0], 1);
        xfer(32'h0000_1000, 1'b1, 32'hFFFF_FFFF);
        rc(32'h0000_1000, 32'h0000_0000);
        rc(OFF_CTRL, 32'h0000_0101);
        chk(hresp, 1'b0);
        conclude;
    end
endmodule // tb

// file: hdl/power_stage.sv
`timescale 1ns/1ps
// Contract
// - Sample block input once per program cycle
// - Pick-up without block asserts start, starts timer
// - Pick-up with block asserts blocked, no timing
// - Block during start drops start, releases timer
// - Blocking emits time-stamped event with measurements
// - Definite-time delay only
// - ON/OFF events per change, selectable
// - Four stages with separate event codes
// - Events carry stamp and process data
// - Circular log of twelve newest entries
// - Log written only on ON events
// - Log entry fields: stamp, name, powers, time, group
// - Condition code 0 normal to 3 blocked
// - Measurement code 0..3, 4 undefined
// - Node state 1 on to 5 off
// - Measured over pick-up ratio, 0.01 p.u.
// - Measured over nominal ratio, 0.01 p.u.
// - Remaining trip time in 5 ms steps
// - Pick-up in use follows setting group
// - Forcing mode lets software drive block
// - Release at 97 or 103 percent
// - 1 ms stamps, instant start and trip share stamp
module power_stage
    import power_stage_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF,
    parameter int MS_CYCLES   = MS_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Measurements and blocking matrix
    input  wire logic [NST-1:0][PW-1:0] meas_power,
    input  wire logic [2:0]            setting_group,
    input  wire logic [NST-1:0]        block_in,
    // Stage outputs
    output logic      [NST-1:0]        start_out,
    output logic      [NST-1:0]        trip_out,
    output logic      [NST-1:0]        blocked_out,
    // Event stream to the common event buffer
    output logic                       evt_valid,
    output logic      [4:0]            evt_code,
    output logic      [31:0]           evt_stamp,
    output logic      [PW-1:0]         evt_power
);

    typedef struct packed {
        logic [NST-1:0]                     sync1;
        logic [NST-1:0]                     sync2;
        logic [NST-1:0]                     blk;
        logic [TW-1:0]                      tick_cnt;
        logic [16:0]                        ms_cnt;
        logic [31:0]                        stamp;
        logic [31:0]                        tick_stamp;
        stage_e [NST-1:0]                   st;
        logic [NST-1:0][TW-1:0]             timer;
        logic [NST-1:0]                     pu_act;
        logic [NST-1:0][HIST_DEPTH-1:0][PW-1:0] hist;
        logic [NST-1:0]                     start;
        logic [NST-1:0]                     trip;
        logic [NST-1:0]                     blocked;
        logic [NEVT-1:0]                    pend;
        logic                               evt_valid;
        logic [4:0]                         evt_code;
        logic [31:0]                        evt_stamp;
        logic [PW-1:0]                      evt_power;
        log_s [LOG_DEPTH-1:0]               log;
        logic [3:0]                         wptr;
        logic [3:0]                         lcount;
        logic                               under;
        logic                               force_en;
        logic [NST-1:0]                     soft_blk;
        logic [2:0]                         node;
        logic [2:0]                         msel;
        logic [NEVT-1:0]                    evt_en;
        logic [3:0]                         log_sel;
        logic [PW-1:0]                      nominal;
        logic [NST-1:0][TW-1:0]             delay;
        logic [NST-1:0][NGRP-1:0][PW-1:0]   pick;
        logic [NST-1:0][PW-1:0]             pick_used;
        logic [NST-1:0][PW-1:0]             ratio_set;
        logic [NST-1:0][PW-1:0]             ratio_nom;
        logic [11:0]                        a_addr;
        logic                               a_wr;
        logic [31:0]                        hrdata;
    } state_s;

    state_s q;
    state_s n;

    // Signed ratio in hundredths; a zero divisor reads as zero
    function automatic logic [PW-1:0] ratio(input logic [PW-1:0] num,
                                            input logic [PW-1:0] den);
        logic signed [63:0] prod;
        logic signed [63:0] quo;
        prod = 64'(signed'(num)) * 64'(PCT_SCALE);
        quo  = 64'sd0;
        if (den != '0) begin
            quo = prod / 64'(signed'(den));
        end
        return quo[PW-1:0];
    endfunction

    function automatic logic [1:0] cond_code(input stage_e s);
        case (s)
            ST_START:   cond_code = 2'd1;
            ST_TRIP:    cond_code = 2'd2;
            ST_BLOCKED: cond_code = 2'd3;
            default:    cond_code = 2'd0;
        endcase
    endfunction

    always_comb begin
        logic            tick;
        logic            sel;
        logic            node_blk;
        logic            act;
        logic            beff;
        logic            mapped;
        logic            found;
        logic [11:0]     off;
        logic [31:0]     rd;
        logic [1:0]      si;
        logic [2:0]      ki;
        logic [NEVT-1:0] newev;
        logic [NEVT-1:0] pick1;
        logic signed [63:0] m100;
        logic signed [63:0] p;
        log_s            ent;
        tick     = 1'b0;
        sel      = 1'b0;
        node_blk = 1'b0;
        act      = 1'b0;
        beff     = 1'b0;
        mapped   = 1'b0;
        found    = 1'b0;
        off      = '0;
        rd       = '0;
        si       = '0;
        ki       = '0;
        newev    = '0;
        pick1    = '0;
        m100     = '0;
        p        = '0;
        ent      = '0;
        n        = q;

        // Blocking matrix input is asynchronous to hclk
        n.sync1 = block_in;
        n.sync2 = q.sync1;

        // Millisecond time stamp
        if (q.ms_cnt == 17'(MS_CYCLES - 1)) begin
            n.ms_cnt = '0;
            n.stamp  = q.stamp + 32'h0000_0001;
        end else begin
            n.ms_cnt = q.ms_cnt + 17'd1;
        end

        // Program-cycle tick
        tick = (q.tick_cnt == TW'(TICK_CYCLES - 1));
        n.tick_cnt = tick ? '0 : q.tick_cnt + TW'(1);

        node_blk = (q.node == NODE_BLOCKED) || (q.node == NODE_TSTBLK);

        for (int s = 0; s < NST; s++) begin
            // Pick-up in use tracks the live setting group
            n.pick_used[s] = q.pick[s][setting_group];
        end

        if (tick) begin
            n.tick_stamp = q.stamp;
            n.blk = q.sync2;
            for (int s = 0; s < NST; s++) begin
                n.hist[s] = {q.hist[s][HIST_DEPTH-2:0], meas_power[s]};
                n.ratio_set[s] = ratio(meas_power[s], q.pick_used[s]);
                n.ratio_nom[s] = ratio(meas_power[s], q.nominal);
                m100 = 64'(signed'(meas_power[s])) * 64'(PCT_SCALE);
                p    = 64'(signed'(q.pick_used[s]));
                // Hysteresis only applies once pick-up is active
                if (!q.under) begin
                    act = q.pu_act[s] ? (m100 >= p * 64'(REL_OVER_PCT))
                                      : (m100 >= p * 64'(PCT_SCALE));
                end else begin
                    act = q.pu_act[s] ? (m100 <= p * 64'(REL_UNDER_PCT))
                                      : (m100 <= p * 64'(PCT_SCALE));
                end
                beff = n.blk[s] | node_blk
                     | (q.force_en & q.soft_blk[s]);
                n.pu_act[s] = act && (q.node != NODE_OFF);

                if (q.node == NODE_OFF || !act) begin
                    n.st[s]    = ST_NORMAL;
                    n.timer[s] = '0;
                end else if (beff) begin
                    // Release exactly as on drop-out, then hold blocked
                    n.st[s]    = ST_BLOCKED;
                    n.timer[s] = '0;
                end else begin
                    case (q.st[s])
                        ST_NORMAL, ST_BLOCKED: begin
                            // Definite time only; zero delay trips at once
                            if (q.delay[s] == '0) begin
                                n.st[s] = ST_TRIP;
                            end else begin
                                n.st[s]    = ST_START;
                                n.timer[s] = q.delay[s];
                            end
                        end
                        ST_START: begin
                            if (q.timer[s] <= TW'(1)) begin
                                n.st[s]    = ST_TRIP;
                                n.timer[s] = '0;
                            end else begin
                                n.timer[s] = q.timer[s] - TW'(1);
                            end
                        end
                        ST_TRIP: n.st[s] = ST_TRIP;
                        default: n.st[s] = ST_NORMAL;
                    endcase
                end

                n.start[s]   = (n.st[s] == ST_START) || (n.st[s] == ST_TRIP);
                n.trip[s]    = (n.st[s] == ST_TRIP);
                n.blocked[s] = (n.st[s] == ST_BLOCKED);
                // Separate event slots per stage and per edge
                newev[s*NKIND + 0] = n.start[s] & ~q.start[s];
                newev[s*NKIND + 1] = ~n.start[s] & q.start[s];
                newev[s*NKIND + 2] = n.trip[s] & ~q.trip[s];
                newev[s*NKIND + 3] = ~n.trip[s] & q.trip[s];
                newev[s*NKIND + 4] = n.blocked[s] & ~q.blocked[s];
                newev[s*NKIND + 5] = ~n.blocked[s] & q.blocked[s];
            end
        end

        // Drain pending events one per cycle, lowest slot first;
        // new edges are OR-ed in so a tick never loses one
        pick1 = q.pend & (~q.pend + NEVT'(1));
        n.pend = (q.pend & ~pick1) | newev;
        n.evt_valid = 1'b0;
        for (int e = 0; e < NEVT; e++) begin
            if (pick1[e]) begin
                si = 2'(e / NKIND);
                ki = 3'(e % NKIND);
                n.evt_valid = q.evt_en[e];
                n.evt_code  = {si, ki};
                n.evt_stamp = q.tick_stamp;
                n.evt_power = q.hist[si][0];
                if (!ki[0]) begin
                    // Only ON edges are logged, oldest slot overwritten
                    ent.stamp     = q.tick_stamp;
                    ent.code      = {si, ki};
                    ent.grp       = setting_group;
                    ent.pre_trig  = q.hist[si][PRE_TRIG_TAP];
                    ent.fault     = q.hist[si][0];
                    ent.pre_fault = q.hist[si][HIST_DEPTH-1];
                    ent.remain    = (q.st[si] == ST_START) ? q.timer[si] : '0;
                    n.log[q.wptr] = ent;
                    n.wptr = (q.wptr == 4'(LOG_DEPTH - 1)) ?
                             '0 : q.wptr + 4'd1;
                    if (q.lcount != 4'(LOG_DEPTH)) begin
                        n.lcount = q.lcount + 4'd1;
                    end
                end
            end
        end

        // AHB-Lite data phase: write lands one cycle after its address
        sel = hsel & htrans[1] & hready;
        n.a_wr = sel & hwrite & (haddr[31:12] == '0);
        n.a_addr = haddr[11:0];
        if (q.a_wr) begin
            off = q.a_addr;
            case (off)
                OFF_CTRL: begin
                    n.under    = hwdata[CTRL_UNDER];
                    n.force_en = hwdata[CTRL_FORCE];
                    n.soft_blk = hwdata[CTRL_SOFTBLK +: NST];
                    n.node     = hwdata[CTRL_NODE +: 3];
                    n.msel     = hwdata[CTRL_MSEL +: 3];
                end
                OFF_EVT_EN:  n.evt_en  = hwdata[NEVT-1:0];
                OFF_LOG_SEL: n.log_sel = hwdata[3:0];
                OFF_NOMINAL: n.nominal = hwdata;
                default: begin
                    if (off[11:6] == SEG_STAGE && off[3:2] == 2'd0) begin
                        n.delay[off[5:4]] = hwdata[TW-1:0];
                    end
                    if (off[11:7] == SEG_PICK) begin
                        n.pick[off[6:5]][off[4:2]] = hwdata;
                    end
                end
            endcase
        end

        // Read data is prepared in the address phase
        off = haddr[11:0];
        mapped = (haddr[31:12] == '0);
        found = 1'b1;
        case (off)
            OFF_CTRL: begin
                rd[CTRL_UNDER]          = q.under;
                rd[CTRL_FORCE]          = q.force_en;
                rd[CTRL_SOFTBLK +: NST] = q.soft_blk;
                rd[CTRL_NODE +: 3]      = q.node;
                rd[CTRL_MSEL +: 3]      = q.msel;
            end
            OFF_EVT_EN: rd[NEVT-1:0] = q.evt_en;
            OFF_STATUS: begin
                for (int s = 0; s < NST; s++) begin
                    rd[2*s +: 2] = cond_code(q.st[s]);
                end
                rd[10:8]  = (q.msel > 3'd3) ? MSEL_UNDEF : q.msel;
                rd[14:12] = q.node;
            end
            OFF_LOG_SEL:  rd[3:0] = q.log_sel;
            OFF_LOG_INFO: rd[7:0] = {q.lcount, q.wptr};
            OFF_NOMINAL:  rd = q.nominal;
            default: begin
                found = 1'b0;
                if (off >= OFF_LOG_W0 && off < OFF_LOG_W0 + 12'h018) begin
                    found = 1'b1;
                    ent = q.log[q.log_sel < 4'(LOG_DEPTH) ? q.log_sel : 4'd0];
                    case (off[4:2])
                        3'd5: rd = ent.stamp;
                        3'd6: rd[10:0] = {ent.grp, 3'd0, ent.code};
                        3'd7: rd = ent.pre_trig;
                        3'd0: rd = ent.fault;
                        3'd1: rd = ent.pre_fault;
                        3'd2: rd[TW-1:0] = ent.remain;
                        default: rd = '0;
                    endcase
                end
                if (off[11:6] == SEG_STAGE) begin
                    found = 1'b1;
                    case (off[3:2])
                        2'd0: rd[TW-1:0] = q.delay[off[5:4]];
                        2'd1: rd = q.ratio_set[off[5:4]];
                        2'd2: rd = q.ratio_nom[off[5:4]];
                        default: rd[TW-1:0] =
                            (q.st[off[5:4]] == ST_START) ?
                            q.timer[off[5:4]] : '0;
                    endcase
                end
                if (off[11:6] == SEG_STAGE2 && !off[3]) begin
                    found = 1'b1;
                    rd = off[2] ? q.hist[off[5:4]][0] : q.pick_used[off[5:4]];
                end
                if (off[11:7] == SEG_PICK) begin
                    found = 1'b1;
                    rd = q.pick[off[6:5]][off[4:2]];
                end
            end
        endcase
        if (sel && !hwrite) begin
            n.hrdata = (mapped && found) ? rd : '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q          <= '0;
            q.node     <= NODE_ON;
            q.evt_en   <= EVT_EN_RST;
            q.nominal  <= NOMINAL_RST;
            q.delay    <= {NST{DELAY_RST}};
        end else begin
            q <= n;
        end
    end

    assign hrdata      = q.hrdata;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign start_out   = q.start;
    assign trip_out    = q.trip;
    assign blocked_out = q.blocked;
    assign evt_valid   = q.evt_valid;
    assign evt_code    = q.evt_code;
    assign evt_stamp   = q.evt_stamp;
    assign evt_power   = q.evt_power;

endmodule // power_stage

// file: hdl/power_stage_pkg.sv
package power_stage_pkg;

    // Geometry
    localparam int NST        = 4;   // Independent stage instances
    localparam int NGRP       = 8;   // Setting groups
    localparam int NKIND      = 6;   // Event kinds per stage
    localparam int NEVT       = NST * NKIND;
    localparam int LOG_DEPTH  = 12;
    localparam int PW         = 32;  // Power words, 0.001 MVA units
    localparam int TW         = 19;  // Timer width in program cycles

    // Timing
    localparam int CLK_MHZ        = 100;
    localparam int PROG_CYCLE_MS  = 5;
    localparam int STAMP_RES_MS   = 1;
    localparam int PRE_TRIG_MS    = 20;
    localparam int PRE_FAULT_MS   = 200;
    localparam int TICK_CYCLES_DEF = PROG_CYCLE_MS * 1000 * CLK_MHZ;
    localparam int MS_CYCLES_DEF   = STAMP_RES_MS * 1000 * CLK_MHZ;
    localparam int PRE_TRIG_TAP   = PRE_TRIG_MS / PROG_CYCLE_MS;
    localparam int HIST_DEPTH     = PRE_FAULT_MS / PROG_CYCLE_MS + 1;

    // Release hysteresis, percent of pick-up
    localparam int REL_OVER_PCT   = 97;
    localparam int REL_UNDER_PCT  = 103;
    localparam int PCT_SCALE      = 100;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL     = 12'h000;
    localparam logic [11:0] OFF_EVT_EN   = 12'h004;
    localparam logic [11:0] OFF_STATUS   = 12'h008;
    localparam logic [11:0] OFF_LOG_SEL  = 12'h00C;
    localparam logic [11:0] OFF_LOG_INFO = 12'h010;
    localparam logic [11:0] OFF_LOG_W0   = 12'h014;
    localparam logic [11:0] OFF_NOMINAL  = 12'h030;
    localparam logic [5:0]  SEG_STAGE    = 6'h01;  // 0x040 + s*0x10
    localparam logic [5:0]  SEG_STAGE2   = 6'h02;  // 0x080 + s*0x10
    localparam logic [4:0]  SEG_PICK     = 5'h02;  // 0x100 + s*0x20 + g*4

    // Control fields
    localparam int CTRL_UNDER   = 0;
    localparam int CTRL_FORCE   = 1;
    localparam int CTRL_SOFTBLK = 4;
    localparam int CTRL_NODE    = 8;
    localparam int CTRL_MSEL    = 12;

    // Encodings and reset values
    localparam logic [2:0]  NODE_ON      = 3'h1;
    localparam logic [2:0]  NODE_BLOCKED = 3'h2;
    localparam logic [2:0]  NODE_TEST    = 3'h3;
    localparam logic [2:0]  NODE_TSTBLK  = 3'h4;
    localparam logic [2:0]  NODE_OFF     = 3'h5;
    localparam logic [2:0]  MSEL_UNDEF   = 3'h4;
    localparam logic [23:0] EVT_EN_RST   = 24'hFF_FFFF;
    localparam logic [31:0] NOMINAL_RST  = 32'h0000_2710;
    localparam logic [TW-1:0] DELAY_RST  = 19'h0_0008;

    typedef enum logic [1:0] {
        ST_NORMAL  = 2'b00,
        ST_START   = 2'b01,
        ST_TRIP    = 2'b11,
        ST_BLOCKED = 2'b10
    } stage_e;

    typedef struct packed {
        logic [31:0]   stamp;
        logic [4:0]    code;
        logic [2:0]    grp;
        logic [PW-1:0] pre_trig;
        logic [PW-1:0] fault;
        logic [PW-1:0] pre_fault;
        logic [TW-1:0] remain;
    } log_s;

endpackage
